/* hdl/stdr_timer.sv */
// APB-reached 16-bit timer data registers with a shared high-byte latch.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Counter readable and writable as two bytes.
// - Counter bytes pass through an 8-bit latch.
// - One latch shared by all 16-bit registers.
// - Counter write blocks matches on next tick.
// - Counter changes while running may skip matches.
// - Three compare values checked every timer tick.
// - Match drives flag and compare output pin.
// - Compare writes update both bytes together.
// - Capture event copies counter into capture value.
// - Capture value can serve as counter TOP.
// - Capture bytes read as one snapshot.
// - Capture edge: zero falling, one rising.
// - Capture as TOP disconnects the capture pin.
module stdr_timer #(
    parameter int TICK_DIV = stdr_pkg::TICK_DIV_DEFAULT // pclk cycles per timer tick.
) (
    input  wire logic        pclk,                 // System clock, 50 MHz.
    input  wire logic        presetn,              // Asynchronous reset, active low.
    input  wire logic        psel,                 // APB select.
    input  wire logic        penable,              // APB enable.
    input  wire logic        pwrite,               // APB direction, 1 for write.
    input  wire logic [11:0] paddr,                // APB byte address.
    input  wire logic [31:0] pwdata,               // APB write data.
    output logic      [31:0] prdata,               // APB read data.
    output logic             pready,               // APB ready.
    output logic             pslverr,              // APB error for unmapped words.
    input  wire logic        capture_input_pin,    // Capture input pin.
    output logic             compare_output_pin_a, // Compare output pin A.
    output logic             compare_output_pin_b, // Compare output pin B.
    output logic             compare_output_pin_c  // Compare output pin C.
);
    logic [15:0] counter_value_q;     // Running counter.
    logic [15:0] compare_value_a_q;   // Compare value A.
    logic [15:0] compare_value_b_q;   // Compare value B.
    logic [15:0] compare_value_c_q;   // Compare value C.
    logic [15:0] capture_value_q;     // Captured counter value.
    logic [7:0]  temp_high_q;         // Shared high-byte latch.
    logic [stdr_pkg::CTRL_WIDTH-1:0] ctrl_q;  // Control bits.
    logic [stdr_pkg::FLAG_WIDTH-1:0] flags_q; // Sticky event flags.
    logic        block_q;             // Matches blocked on the next tick.
    logic [31:0] div_cnt_q;           // Timer tick divider.
    logic        tick_q;              // Timer tick enable pulse.
    logic        pready_q;            // Ready, one wait state per transfer.
    logic        pslverr_q;           // Error answer.
    logic [31:0] prdata_q;            // Read data register.
    logic        pin_a_w;             // Pin A from its channel flop.
    logic        pin_b_w;             // Pin B from its channel flop.
    logic        pin_c_w;             // Pin C from its channel flop.
    logic        match_a_w;           // Match pulse A.
    logic        match_b_w;           // Match pulse B.
    logic        match_c_w;           // Match pulse C.
    logic        cap_event_w;         // Capture event pulse.
    logic        top_hit_w;           // Counter at capture TOP on a tick.
    logic        cap_top;             // Capture value acts as TOP.

    // Word index, access phase and completion terms of the APB slave.
    logic [9:0] word_idx;  // Word index from the byte address.
    logic       access;    // Access phase, during the wait state.
    logic       done;      // Completing edge of a transfer.
    logic       wr_done;   // Write takes effect.
    logic       rd_load;   // Read data is loaded.
    logic       mapped;    // Address hits a register.

    assign word_idx = paddr[11:2];
    assign access   = psel && penable && !pready_q;
    assign done     = psel && penable && pready_q;
    assign wr_done  = done && pwrite && mapped;
    assign rd_load  = access && !pwrite && mapped;
    assign cap_top  = ctrl_q[stdr_pkg::CTRL_TOP_BIT];
    assign top_hit_w = tick_q && cap_top && (counter_value_q == capture_value_q);

    // Address decode; any word outside the map gets an error answer.
    always_comb begin
        unique case (word_idx[7:0])
            stdr_pkg::IDX_CNT_LO, stdr_pkg::IDX_CNT_HI,
            stdr_pkg::IDX_CAP_LO, stdr_pkg::IDX_CAP_HI,
            stdr_pkg::IDX_CMPA_LO, stdr_pkg::IDX_CMPA_HI,
            stdr_pkg::IDX_CMPB_LO, stdr_pkg::IDX_CMPB_HI,
            stdr_pkg::IDX_CMPC_LO, stdr_pkg::IDX_CMPC_HI,
            stdr_pkg::IDX_CTRL, stdr_pkg::IDX_FLAGS: mapped = (word_idx[9:8] == 2'b00);
            default: mapped = 1'b0;
        endcase
    end

    // One wait state lets read data come straight from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && !mapped;
        end
    end

    // Read data; a counter or capture low-byte read also fills the latch with the matching high byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_load) begin
            unique case (word_idx[7:0])
                stdr_pkg::IDX_CNT_LO:  prdata_q <= {24'h00_0000, counter_value_q[7:0]};
                stdr_pkg::IDX_CNT_HI:  prdata_q <= {24'h00_0000, temp_high_q};
                stdr_pkg::IDX_CAP_LO:  prdata_q <= {24'h00_0000, capture_value_q[7:0]};
                stdr_pkg::IDX_CAP_HI:  prdata_q <= {24'h00_0000, temp_high_q};
                stdr_pkg::IDX_CMPA_LO: prdata_q <= {24'h00_0000, compare_value_a_q[7:0]};
                stdr_pkg::IDX_CMPA_HI: prdata_q <= {24'h00_0000, compare_value_a_q[15:8]};
                stdr_pkg::IDX_CMPB_LO: prdata_q <= {24'h00_0000, compare_value_b_q[7:0]};
                stdr_pkg::IDX_CMPB_HI: prdata_q <= {24'h00_0000, compare_value_b_q[15:8]};
                stdr_pkg::IDX_CMPC_LO: prdata_q <= {24'h00_0000, compare_value_c_q[7:0]};
                stdr_pkg::IDX_CMPC_HI: prdata_q <= {24'h00_0000, compare_value_c_q[15:8]};
                stdr_pkg::IDX_CTRL:    prdata_q <= {29'h0000_0000, ctrl_q};
                stdr_pkg::IDX_FLAGS:   prdata_q <= {28'h000_0000, flags_q};
                default:               prdata_q <= 32'h0000_0000;
            endcase
        end else if (access) begin
            prdata_q <= 32'h0000_0000; // Writes and errors return zero.
        end
    end

    // The one shared latch: counter and compare high-byte writes load it, counter and capture low-byte reads fill it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_high_q <= stdr_pkg::VAL8_RESET;
        end else if (rd_load && word_idx[7:0] == stdr_pkg::IDX_CNT_LO) begin
            temp_high_q <= counter_value_q[15:8];
        end else if (rd_load && word_idx[7:0] == stdr_pkg::IDX_CAP_LO) begin
            temp_high_q <= capture_value_q[15:8];
        end else if (wr_done && (word_idx[7:0] == stdr_pkg::IDX_CNT_HI
                                 || word_idx[7:0] == stdr_pkg::IDX_CMPA_HI
                                 || word_idx[7:0] == stdr_pkg::IDX_CMPB_HI
                                 || word_idx[7:0] == stdr_pkg::IDX_CMPC_HI)) begin
            temp_high_q <= pwdata[7:0];
        end
    end

    // Timer tick divider: one pulse every TICK_DIV pclk cycles while running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 32'h0000_0000;
            tick_q    <= 1'b0;
        end else if (!ctrl_q[stdr_pkg::CTRL_RUN_BIT]) begin
            div_cnt_q <= 32'h0000_0000;
            tick_q    <= 1'b0;
        end else if (div_cnt_q >= 32'(TICK_DIV - 1)) begin
            div_cnt_q <= 32'h0000_0000;
            tick_q    <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 32'h0000_0001;
            tick_q    <= 1'b0;
        end
    end

    // Counter: a low-byte write loads both halves at once and beats the tick.
    // Writing while running can jump past a compare value; nothing guards it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_q <= stdr_pkg::VAL16_RESET;
        end else if (wr_done && word_idx[7:0] == stdr_pkg::IDX_CNT_LO) begin
            counter_value_q <= {temp_high_q, pwdata[7:0]};
        end else if (top_hit_w) begin
            counter_value_q <= stdr_pkg::VAL16_RESET;
        end else if (tick_q) begin
            counter_value_q <= counter_value_q + 16'h0001;
        end
    end

    // A counter write blocks compare matches until the next tick has passed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (wr_done && word_idx[7:0] == stdr_pkg::IDX_CNT_LO) begin
            block_q <= 1'b1;
        end else if (tick_q) begin
            block_q <= 1'b0;
        end
    end

    // Compare values change as whole 16-bit words on the low-byte write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_a_q <= stdr_pkg::VAL16_RESET;
            compare_value_b_q <= stdr_pkg::VAL16_RESET;
            compare_value_c_q <= stdr_pkg::VAL16_RESET;
        end else if (wr_done) begin
            if (word_idx[7:0] == stdr_pkg::IDX_CMPA_LO) begin
                compare_value_a_q <= {temp_high_q, pwdata[7:0]};
            end
            if (word_idx[7:0] == stdr_pkg::IDX_CMPB_LO) begin
                compare_value_b_q <= {temp_high_q, pwdata[7:0]};
            end
            if (word_idx[7:0] == stdr_pkg::IDX_CMPC_LO) begin
                compare_value_c_q <= {temp_high_q, pwdata[7:0]};
            end
        end
    end

    // Capture copies the counter; software cannot write this register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_q <= stdr_pkg::VAL16_RESET;
        end else if (cap_event_w) begin
            capture_value_q <= counter_value_q;
        end
    end

    // Control register write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else if (wr_done && word_idx[7:0] == stdr_pkg::IDX_CTRL) begin
            ctrl_q <= pwdata[stdr_pkg::CTRL_WIDTH-1:0];
        end
    end

    // Sticky flags, write one to clear; a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            logic [stdr_pkg::FLAG_WIDTH-1:0] set_v;
            logic [stdr_pkg::FLAG_WIDTH-1:0] clr_v;
            set_v = '0;
            clr_v = '0;
            set_v[stdr_pkg::FLAG_CMPA_BIT] = match_a_w;
            set_v[stdr_pkg::FLAG_CMPB_BIT] = match_b_w;
            set_v[stdr_pkg::FLAG_CMPC_BIT] = match_c_w;
            set_v[stdr_pkg::FLAG_CAP_BIT]  = cap_event_w || top_hit_w;
            if (wr_done && word_idx[7:0] == stdr_pkg::IDX_FLAGS) begin
                clr_v = pwdata[stdr_pkg::FLAG_WIDTH-1:0];
            end
            flags_q <= (flags_q & ~clr_v) | set_v;
        end
    end

    // Three identical compare channels.
    stdr_cmp_chan #(.WIDTH(16)) u_cmp_a (
        .pclk(pclk), .presetn(presetn), .tick(tick_q), .block_match(block_q),
        .counter(counter_value_q), .compare(compare_value_a_q),
        .match_q(match_a_w), .pin_q(pin_a_w)
    );
    stdr_cmp_chan #(.WIDTH(16)) u_cmp_b (
        .pclk(pclk), .presetn(presetn), .tick(tick_q), .block_match(block_q),
        .counter(counter_value_q), .compare(compare_value_b_q),
        .match_q(match_b_w), .pin_q(pin_b_w)
    );
    stdr_cmp_chan #(.WIDTH(16)) u_cmp_c (
        .pclk(pclk), .presetn(presetn), .tick(tick_q), .block_match(block_q),
        .counter(counter_value_q), .compare(compare_value_c_q),
        .match_q(match_c_w), .pin_q(pin_c_w)
    );

    // Capture pin edge detection; disconnected while capture acts as TOP.
    stdr_cap_edge u_cap (
        .pclk(pclk), .presetn(presetn), .pin(capture_input_pin),
        .rising_sel(ctrl_q[stdr_pkg::CTRL_EDGE_BIT]),
        .disconnect(cap_top),
        .event_q(cap_event_w)
    );

    // Outputs straight from flops.
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign compare_output_pin_a = pin_a_w;
    assign compare_output_pin_b = pin_b_w;
    assign compare_output_pin_c = pin_c_w;
endmodule : stdr_timer
`default_nettype wire

/* hdl/stdr_pkg.sv */
// Constants shared by the 16-bit timer data register block.
package stdr_pkg;
    // Register indexes; the APB byte address is four times the index.
    localparam logic [7:0] IDX_CNT_LO  = 8'h94; // Counter value, low byte.
    localparam logic [7:0] IDX_CNT_HI  = 8'h95; // Counter value, high byte.
    localparam logic [7:0] IDX_CAP_LO  = 8'h96; // Capture value, low byte.
    localparam logic [7:0] IDX_CAP_HI  = 8'h97; // Capture value, high byte.
    localparam logic [7:0] IDX_CMPA_LO = 8'h98; // Compare value A, low byte.
    localparam logic [7:0] IDX_CMPA_HI = 8'h99; // Compare value A, high byte.
    localparam logic [7:0] IDX_CMPB_LO = 8'h9a; // Compare value B, low byte.
    localparam logic [7:0] IDX_CMPB_HI = 8'h9b; // Compare value B, high byte.
    localparam logic [7:0] IDX_CMPC_LO = 8'h9c; // Compare value C, low byte.
    localparam logic [7:0] IDX_CMPC_HI = 8'h9d; // Compare value C, high byte.
    localparam logic [7:0] IDX_CTRL    = 8'h90; // Control register.
    localparam logic [7:0] IDX_FLAGS   = 8'h91; // Event flag register.

    // Reset values of the data registers and the latch.
    localparam logic [15:0] VAL16_RESET = 16'h0000;
    localparam logic [7:0]  VAL8_RESET  = 8'h00;

    // Control register fields.
    localparam int CTRL_RUN_BIT  = 0; // Counter runs when set.
    localparam int CTRL_EDGE_BIT = 1; // Capture edge select: 1 rising, 0 falling.
    localparam int CTRL_TOP_BIT  = 2; // Capture value acts as counter TOP.
    localparam int CTRL_WIDTH    = 3; // Implemented control bits.

    // Flag register fields, write one to clear.
    localparam int FLAG_CMPA_BIT = 0; // Compare A matched.
    localparam int FLAG_CMPB_BIT = 1; // Compare B matched.
    localparam int FLAG_CMPC_BIT = 2; // Compare C matched.
    localparam int FLAG_CAP_BIT  = 3; // Capture event or TOP reached.
    localparam int FLAG_WIDTH    = 4; // Implemented flag bits.

    // Default timer clock divider: one tick every pclk.
    localparam int TICK_DIV_DEFAULT = 1;
endpackage : stdr_pkg

/* hdl/stdr_cmp_chan.sv */
// One output compare channel: match detection and compare pin toggle.
`timescale 1ns/1ps
`default_nettype none
module stdr_cmp_chan #(
    parameter int WIDTH = 16                  // Counter width.
) (
    input  wire logic             pclk,       // System clock.
    input  wire logic             presetn,    // Asynchronous reset, active low.
    input  wire logic             tick,       // Timer clock enable pulse.
    input  wire logic             block_match, // Suppress the match on this tick.
    input  wire logic [WIDTH-1:0] counter,    // Current counter value.
    input  wire logic [WIDTH-1:0] compare,    // Compare value of this channel.
    output logic                  match_q,    // One-cycle match pulse.
    output logic                  pin_q       // Compare output pin level.
);
    // Equality is sampled on the timer tick; the pulse appears one cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= tick && !block_match && (counter == compare);
        end
    end

    // The pin toggles on every match, giving a simple waveform output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else if (tick && !block_match && (counter == compare)) begin
            pin_q <= !pin_q;
        end
    end
endmodule : stdr_cmp_chan
`default_nettype wire

/* hdl/stdr_cap_edge.sv */
// Capture pin edge detector with selectable edge and a disconnect input.
`timescale 1ns/1ps
`default_nettype none
module stdr_cap_edge (
    input  wire logic pclk,        // System clock.
    input  wire logic presetn,     // Asynchronous reset, active low.
    input  wire logic pin,         // Capture input pin, synchronous to pclk.
    input  wire logic rising_sel,  // 1 selects rising edge, 0 falling.
    input  wire logic disconnect,  // Pin disconnected while capture is TOP.
    output logic      event_q      // One-cycle capture event pulse.
);
    logic pin_prev_q; // Pin level in the previous cycle.

    // Remember the pin so that edges can be seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin;
        end
    end

    // Edge selection and disconnect; a disconnected pin raises no event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_q <= 1'b0;
        end else if (disconnect) begin
            event_q <= 1'b0;
        end else if (rising_sel) begin
            event_q <= pin && !pin_prev_q;
        end else begin
            event_q <= !pin && pin_prev_q;
        end
    end
endmodule : stdr_cap_edge
`default_nettype wire

/* verification/stdr_timer_assertions.sv */
// Checker of the register bus answers of the timer data register block.
`timescale 1ns/1ps
`default_nettype none
module stdr_timer_checker #(
    parameter int TICK_DIV = 1 // Timer tick divider, handed on from the design.
) (
    input wire logic        pclk,    // System clock.
    input wire logic        presetn, // Asynchronous reset, active low.
    input wire logic        psel,    // APB select.
    input wire logic        penable, // APB enable.
    input wire logic        pwrite,  // APB direction.
    input wire logic [11:0] paddr,   // APB byte address.
    input wire logic [31:0] prdata,  // APB read data.
    input wire logic        pready,  // APB ready.
    input wire logic        pslverr  // APB error.
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An access phase that has not yet been answered.
    sequence s_take;
        psel && penable && !pready;
    endsequence
    // The answer stands for exactly one cycle.
    sequence s_done;
        pready ##1 !pready;
    endsequence
    a_ready_one_wait: assert property (s_take |=> s_done)
        else $error("pready did not answer after one wait state");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready raised outside an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr raised without pready");
    a_unmapped_err: assert property (s_take ##0 (paddr[11:10] != 2'h0) |=> pslverr)
        else $error("unmapped word answered without error");
    a_mapped_ok: assert property (s_take ##0 (paddr[11:10] == 2'h0)
        ##0 (paddr[9:2] inside {[8'h94:8'h9d]}) |=> !pslverr)
        else $error("data register answered with error");
    a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_rdata_hold: assert property (!penable |=> $stable(prdata))
        else $error("read data changed outside an access");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
endmodule : stdr_timer_checker
bind stdr_timer stdr_timer_checker #(.TICK_DIV(TICK_DIV)) u_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* verification/stdr_cap_src.sv */
// Model of the external source that drives the capture input pin.
`timescale 1ns/1ps
`default_nettype none
module stdr_cap_src (
    input  wire logic pclk,    // System clock.
    input  wire logic presetn, // Asynchronous reset, active low.
    input  wire logic level,   // Level the bench asks for.
    output logic      pin_q    // Capture pin level.
);
    // A register keeps the pin synchronous to pclk, as the design expects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= level;
        end
    end
endmodule : stdr_cap_src
`default_nettype wire

/* verification/test_sixteen_bit_timer_data_regs.sv */
// Self-checking testbench of the timer data register block.
`timescale 1ns/1ps
`default_nettype none
module test_sixteen_bit_timer_data_regs;
    logic        pclk      = 1'b0;  // System clock.
    logic        presetn   = 1'b0;  // Reset, active low.
    logic        psel      = 1'b0;  // APB select.
    logic        penable   = 1'b0;  // APB enable.
    logic        pwrite    = 1'b0;  // APB direction.
    logic [11:0] paddr     = 12'h0; // APB address.
    logic [31:0] pwdata    = 32'h0; // APB write data.
    logic [31:0] prdata;            // APB read data.
    logic        pready;            // APB ready.
    logic        pslverr;           // APB error.
    logic        cap_level = 1'b0;  // Level asked of the pin source.
    logic        cap_pin;           // Capture pin.
    logic        pin_a;             // Compare pin A.
    logic        pin_b;             // Compare pin B.
    logic        pin_c;             // Compare pin C.
    int          n_mismatch = 0;    // Mismatches seen.
    int          checked    = 0;    // Comparisons made.
    int          cycles     = 0;    // Cycles run.
    stdr_timer #(.TICK_DIV(1)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input_pin(cap_pin), .compare_output_pin_a(pin_a),
        .compare_output_pin_b(pin_b), .compare_output_pin_c(pin_c));
    stdr_cap_src u_src (.pclk(pclk), .presetn(presetn), .level(cap_level), .pin_q(cap_pin));
    always #10 pclk = ~pclk;
    // A hang is cut short well after the few hundred cycles the run needs.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the edge that samples pready high; only the bench timeout ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, {2'b00, idx, 2'b00}, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic       e;
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, r, e);
        chk_byte(r, exp);
    endtask : rd_chk
    task automatic pin(input logic v);
        @(posedge pclk);
        cap_level <= v;
        repeat (5) @(posedge pclk);
    endtask : pin
    task automatic t_reset_values();
        for (int i = 8'h94; i <= 8'h9d; i++) begin
            rd_chk(8'(i), 8'h00);
        end
    endtask : t_reset_values
    // Byte pairs, the shared latch, a read-only write and an unmapped word.
    task automatic t_access();
        logic [7:0] r;
        logic       e;
        wr(stdr_pkg::IDX_CNT_HI, 8'ha5);
        wr(stdr_pkg::IDX_CNT_LO, 8'h3c);
        rd_chk(stdr_pkg::IDX_CNT_LO, 8'h3c);
        rd_chk(stdr_pkg::IDX_CNT_HI, 8'ha5);
        rd_chk(stdr_pkg::IDX_CNT_LO, 8'h3c);
        rd_chk(stdr_pkg::IDX_CAP_HI, 8'ha5);
        wr(stdr_pkg::IDX_CMPA_HI, 8'h77);
        wr(stdr_pkg::IDX_CMPB_LO, 8'h81);
        rd_chk(stdr_pkg::IDX_CMPB_HI, 8'h77);
        rd_chk(stdr_pkg::IDX_CMPB_LO, 8'h81);
        wr(stdr_pkg::IDX_CMPC_HI, 8'hc3);
        wr(stdr_pkg::IDX_CMPC_LO, 8'h9e);
        rd_chk(stdr_pkg::IDX_CMPC_HI, 8'hc3);
        rd_chk(stdr_pkg::IDX_CMPC_LO, 8'h9e);
        wr(stdr_pkg::IDX_CAP_LO, 8'h55);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h00);
        apb(1'b0, 12'hc00, 8'h00, r, e);
        chk_bit(e, 1'b1);
    endtask : t_access
    // Captures with a stopped counter, each edge choice and the TOP disconnect.
    task automatic t_capture();
        wr(stdr_pkg::IDX_CTRL, 8'h02);
        wr(stdr_pkg::IDX_CNT_HI, 8'h12);
        wr(stdr_pkg::IDX_CNT_LO, 8'h34);
        pin(1'b1);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h34);
        rd_chk(stdr_pkg::IDX_CAP_HI, 8'h12);
        wr(stdr_pkg::IDX_CNT_HI, 8'h56);
        wr(stdr_pkg::IDX_CNT_LO, 8'h78);
        pin(1'b0);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h34);
        wr(stdr_pkg::IDX_CTRL, 8'h00);
        pin(1'b1);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h34);
        pin(1'b0);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h78);
        rd_chk(stdr_pkg::IDX_CAP_HI, 8'h56);
        wr(stdr_pkg::IDX_CTRL, 8'h06);
        pin(1'b1);
        rd_chk(stdr_pkg::IDX_CAP_LO, 8'h78);
        wr(stdr_pkg::IDX_CTRL, 8'h00);
    endtask : t_capture
    // Three channels match in one run; a counter write then hides a match.
    task automatic t_match();
        logic [7:0] r;
        logic       e;
        wr(stdr_pkg::IDX_CNT_HI, 8'h00);
        wr(stdr_pkg::IDX_CNT_LO, 8'hf0);
        wr(stdr_pkg::IDX_CMPA_HI, 8'h01);
        wr(stdr_pkg::IDX_CMPA_LO, 8'h00);
        wr(stdr_pkg::IDX_CMPB_LO, 8'h05);
        wr(stdr_pkg::IDX_CMPC_LO, 8'h0a);
        wr(stdr_pkg::IDX_FLAGS, 8'h0f);
        wr(stdr_pkg::IDX_CTRL, 8'h01);
        repeat (40) @(posedge pclk);
        wr(stdr_pkg::IDX_CTRL, 8'h00);
        chk_bit(pin_a, 1'b1);
        chk_bit(pin_b, 1'b1);
        chk_bit(pin_c, 1'b1);
        rd_chk(stdr_pkg::IDX_FLAGS, 8'h07);
        wr(stdr_pkg::IDX_FLAGS, 8'h0f);
        wr(stdr_pkg::IDX_CTRL, 8'h01);
        wr(stdr_pkg::IDX_CMPA_HI, 8'h02);
        wr(stdr_pkg::IDX_CMPA_LO, 8'h00);
        wr(stdr_pkg::IDX_CNT_HI, 8'h02);
        wr(stdr_pkg::IDX_CNT_LO, 8'h00);
        repeat (10) @(posedge pclk);
        wr(stdr_pkg::IDX_CTRL, 8'h00);
        chk_bit(pin_a, 1'b1);
        rd_chk(stdr_pkg::IDX_FLAGS, 8'h00);
        wr(stdr_pkg::IDX_CNT_HI, 8'h01);
        wr(stdr_pkg::IDX_CNT_LO, 8'hfc);
        wr(stdr_pkg::IDX_CTRL, 8'h01);
        repeat (10) @(posedge pclk);
        wr(stdr_pkg::IDX_CTRL, 8'h00);
        chk_bit(pin_a, 1'b0);
        // With the capture value 0x5678 as TOP the counter wraps to zero and flags it.
        wr(stdr_pkg::IDX_CNT_HI, 8'h56);
        wr(stdr_pkg::IDX_CNT_LO, 8'h70);
        wr(stdr_pkg::IDX_FLAGS, 8'h0f);
        wr(stdr_pkg::IDX_CTRL, 8'h07);
        repeat (20) @(posedge pclk);
        wr(stdr_pkg::IDX_CTRL, 8'h06);
        rd_chk(stdr_pkg::IDX_FLAGS, 8'h08);
        apb(1'b0, {2'b00, stdr_pkg::IDX_CNT_LO, 2'b00}, 8'h00, r, e);
        rd_chk(stdr_pkg::IDX_CNT_HI, 8'h00);
    endtask : t_match
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_access();
        t_capture();
        t_match();
        end_of_test();
    end
endmodule : test_sixteen_bit_timer_data_regs
`default_nettype wire
